/* File: common/grps_pkg.sv */
// Package for the general register pointer and status word block.
// Assumes a 4-bit system register space addressed by a 7-bit nibble index.
package grps_pkg;
  // System register addresses
  localparam logic [6:0] GRPS_ADDR_PTR_HI = 7'h7d;
  localparam logic [6:0] GRPS_ADDR_PTR_LO = 7'h7e;
  localparam logic [6:0] GRPS_ADDR_STATUS = 7'h7f;
  // Reset values
  localparam logic [3:0] GRPS_RST_NIBBLE = 4'h0;
  localparam logic GRPS_RST_BIT = 1'b0;
  // Field positions
  localparam int GRPS_BIT_BANK = 0;
  localparam int GRPS_BIT_DEC = 0;
  localparam int GRPS_BIT_CMP = 3;
  localparam int GRPS_BIT_CY = 2;
  localparam int GRPS_BIT_Z = 1;
  localparam int GRPS_BIT_IXE = 0;
  // Decimal adjust constants and nibble values
  localparam logic [4:0] GRPS_BCD_LIMIT = 5'h09;
  localparam logic [4:0] GRPS_BCD_ADJ = 5'h06;
  localparam logic [3:0] GRPS_ZERO = 4'h0;
  localparam logic [3:0] GRPS_ONE_NIB = 4'h1;
  // ALU operations
  typedef enum logic [1:0] {
    GRPS_OP_NONE,
    GRPS_OP_ADD,
    GRPS_OP_SUB
  } grps_op_t;
endpackage

/* File: verilog/grps_adder.sv */
// Four-bit binary or decimal adder/subtractor with registered result.
// Assumes operands come from logic on the same clock.
`default_nettype none
module grps_adder
  import grps_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sub_i,
  input wire logic dec_i,
  input wire logic cin_i,
  input wire logic [3:0] a_i,
  input wire logic [3:0] b_i,
  output logic [3:0] sum_o,
  output logic cout_o
);
  // Registered outputs of the adder
  typedef struct packed {
    logic [3:0] sum;
    logic cout;
  } grps_add_st_t;
  grps_add_st_t s_q, s_d;
  // Binary step then decimal correction
  always_comb begin
    logic [4:0] raw;
    raw = 5'h00;
    s_d = s_q;
    if (sub_i) begin
      raw = {1'b0, a_i} - {1'b0, b_i} - {4'h0, cin_i};
    end else begin
      raw = {1'b0, a_i} + {1'b0, b_i} + {4'h0, cin_i};
    end
    s_d.sum = raw[3:0];
    s_d.cout = raw[4];
    if (dec_i) begin
      // Decimal adjust: fix digit beyond 9 or on carry/borrow
      if (!sub_i && (raw > GRPS_BCD_LIMIT)) begin
        s_d.sum = raw[3:0] + GRPS_BCD_ADJ[3:0];
        s_d.cout = 1'b1;
      end else if (sub_i && raw[4]) begin
        s_d.sum = raw[3:0] - GRPS_BCD_ADJ[3:0];
      end
    end
    if (srst_i) begin
      s_d.sum = GRPS_ZERO;
      s_d.cout = 1'b0;
    end
  end
  // Result register
  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end
  assign sum_o = s_q.sum;
  assign cout_o = s_q.cout;
endmodule
`default_nettype wire

/* File: verilog/grps_top.sv */
// General register pointer and program status word of a 4-bit core.
// Assumes a nibble-wide system register port on the core clock, with
// read data valid the cycle after the read strobe.
//
// Function
// (RULE1) Pointer is seven bits over two nibbles
// (RULE2) Only four pointer bits are functional
// (RULE3) High nibble picks bank, low picks row
// (RULE4) Only rows 0-7 of banks 0,1
// (RULE5) Low nibble bit 0 is decimal flag
// (RULE6) Status word is four flag bits
// (RULE7) Compare, carry, zero, index flags independent
// (RULE8) Flags condition ALU and record outcomes
// (RULE9) Arithmetic into status stores raw result
// (RULE10) Fixed-zero bits ignore writes, read zero
// (RULE11) All nibbles clear on every reset
// (RULE12) Index modification only when index flag set
// (RULE13) Decimal flag enables decimal adjustment
`default_nettype none
module grps_top
  import grps_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic clk_stop_rst_i,
  input wire logic ce_rst_i,
  input wire logic [6:0] addr_i,
  input wire logic [3:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [3:0] rdata_o,
  input wire logic alu_go_i,
  input wire logic [1:0] alu_op_i,
  input wire logic alu_use_carry_i,
  input wire logic alu_cmp_only_i,
  input wire logic [6:0] alu_dst_i,
  input wire logic [3:0] alu_a_i,
  input wire logic [3:0] alu_b_i,
  input wire logic [10:0] mem_addr_i,
  input wire logic [10:0] index_i,
  output logic [6:0] gr_pointer_o,
  output logic [1:0] gr_bank_o,
  output logic [2:0] gr_row_o,
  output logic decimal_mode_o,
  output logic compare_flag_o,
  output logic carry_flag_o,
  output logic zero_flag_o,
  output logic index_enable_flag_o,
  output logic [10:0] mem_addr_o,
  output logic [3:0] alu_result_o,
  output logic alu_valid_o
);
  // Registered state: pointer, flags, read data, outputs and the pending ALU operation
  typedef struct packed {
    logic [3:0] ptr_hi;
    logic [2:0] ptr_row;
    logic dec;
    logic [3:0] status;
    logic [3:0] rdata;
    logic [10:0] mem_addr;
    logic pend;
    logic pend_cmp;
    logic [6:0] pend_dst;
    logic [3:0] result;
    logic valid;
    logic [6:0] ptr_out;
    logic [1:0] bank_out;
    logic [2:0] row_out;
  } grps_state_t;
  grps_state_t s_q, s_d;

  // Adder results, registered inside the leaf
  logic [3:0] add_sum;
  logic add_cout;

  // Decode shared by reads and writes
  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    hit = (a == r);
  endfunction

  // Assemble the status nibble from individual flags
  function automatic logic [3:0] pack_status(input logic [3:0] st);
    pack_status = st;
  endfunction

  // Carry input honours the carry flag for ADDC/SUBC forms [RULE8]
  logic adder_cin;
  assign adder_cin = alu_use_carry_i & s_q.status[GRPS_BIT_CY];

  // Leaf adder, decimal correction gated by the decimal flag [RULE13]
  grps_adder u_adder (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .sub_i(alu_op_i == GRPS_OP_SUB),
    .dec_i(s_q.dec),
    .cin_i(adder_cin),
    .a_i(alu_a_i),
    .b_i(alu_b_i),
    .sum_o(add_sum),
    .cout_o(add_cout)
  );

  // Next-state logic for registers, flags and derived outputs
  always_comb begin
    logic any_rst;
    logic do_arith;
    logic [3:0] st;
    any_rst = srst_i | clk_stop_rst_i | ce_rst_i;
    do_arith = alu_go_i && (alu_op_i != GRPS_OP_NONE);
    st = s_q.status;
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.pend = do_arith;
    s_d.pend_cmp = alu_cmp_only_i;
    s_d.pend_dst = alu_dst_i;

    // Software writes; bank bits above bit 0 are not stored [RULE10]
    if (wr_i) begin
      if (hit(addr_i, GRPS_ADDR_PTR_HI)) begin
        s_d.ptr_hi = {3'b000, wdata_i[GRPS_BIT_BANK]}; // [RULE2]
      end
      if (hit(addr_i, GRPS_ADDR_PTR_LO)) begin
        s_d.ptr_row = wdata_i[3:1]; // [RULE3]
        s_d.dec = wdata_i[GRPS_BIT_DEC]; // Shared decimal bit [RULE5]
      end
      if (hit(addr_i, GRPS_ADDR_STATUS)) begin
        s_d.status = wdata_i; // [RULE6]
      end
    end

    // Outcome of the previous arithmetic step
    if (s_q.pend) begin
      if (hit(s_q.pend_dst, GRPS_ADDR_STATUS)) begin
        // Raw result replaces flag update, even 0000B with carry [RULE9]
        s_d.status = add_sum;
      end else begin
        // Carry and zero are updated on their own; compare and index keep their value [RULE7]
        st[GRPS_BIT_CY] = add_cout;
        if (s_q.pend_cmp) begin
          // Compare keeps zero only while result stays zero
          st[GRPS_BIT_Z] = s_q.status[GRPS_BIT_Z] & (add_sum == GRPS_ZERO);
        end else begin
          st[GRPS_BIT_Z] = (add_sum == GRPS_ZERO);
          s_d.result = add_sum;
          s_d.valid = 1'b1;
        end
        s_d.status = pack_status(st); // [RULE8]
        if (hit(s_q.pend_dst, GRPS_ADDR_PTR_LO)) begin
          s_d.ptr_row = add_sum[3:1];
          s_d.dec = add_sum[GRPS_BIT_DEC];
        end else if (hit(s_q.pend_dst, GRPS_ADDR_PTR_HI)) begin
          s_d.ptr_hi = {3'b000, add_sum[GRPS_BIT_BANK]}; // [RULE10]
        end
      end
    end

    // Read mux; fixed bits read zero [RULE10]
    s_d.rdata = GRPS_ZERO;
    if (rd_i) begin
      if (hit(addr_i, GRPS_ADDR_PTR_HI)) begin
        s_d.rdata = {3'b000, s_q.ptr_hi[GRPS_BIT_BANK]};
      end else if (hit(addr_i, GRPS_ADDR_PTR_LO)) begin
        s_d.rdata = {s_q.ptr_row, s_q.dec};
      end else if (hit(addr_i, GRPS_ADDR_STATUS)) begin
        s_d.rdata = s_q.status;
      end
    end

    // Pointer: four bank bits and three row bits [RULE1]
    s_d.ptr_out = {s_d.ptr_hi, s_d.ptr_row};
    // Bank is 0 or 1 only, so rows 0-7 of two banks [RULE4]
    s_d.bank_out = {1'b0, s_d.ptr_hi[GRPS_BIT_BANK]};
    s_d.row_out = s_d.ptr_row; // [RULE3]

    // Index modification ORs the index only when enabled [RULE12]
    if (s_d.status[GRPS_BIT_IXE]) begin
      s_d.mem_addr = mem_addr_i | index_i;
    end else begin
      s_d.mem_addr = mem_addr_i;
    end

    // Any of the three resets clears all state here; the leaf adder clears on srst_i only [RULE11]
    if (any_rst) begin
      s_d.ptr_hi = GRPS_RST_NIBBLE;
      s_d.ptr_row = 3'b000;
      s_d.dec = GRPS_RST_BIT;
      s_d.status = GRPS_RST_NIBBLE;
      s_d.rdata = GRPS_ZERO;
      s_d.mem_addr = 11'h000;
      s_d.pend = 1'b0;
      s_d.pend_cmp = 1'b0;
      s_d.pend_dst = 7'h00;
      s_d.result = GRPS_ZERO;
      s_d.valid = 1'b0;
      s_d.ptr_out = 7'h00;
      s_d.bank_out = 2'b00;
      s_d.row_out = 3'b000;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // Outputs straight from flip-flops
  assign rdata_o = s_q.rdata;
  assign gr_pointer_o = s_q.ptr_out;
  assign gr_bank_o = s_q.bank_out;
  assign gr_row_o = s_q.row_out;
  assign decimal_mode_o = s_q.dec;
  assign compare_flag_o = s_q.status[GRPS_BIT_CMP];
  assign carry_flag_o = s_q.status[GRPS_BIT_CY];
  assign zero_flag_o = s_q.status[GRPS_BIT_Z];
  assign index_enable_flag_o = s_q.status[GRPS_BIT_IXE];
  assign mem_addr_o = s_q.mem_addr;
  assign alu_result_o = s_q.result;
  assign alu_valid_o = s_q.valid;
endmodule
`default_nettype wire

/* File: sim/grps_top_checker.sv */
// Checker for the pointer and status word block.
// Sees only the top ports; attached by the bind at the foot.
`default_nettype none
module grps_top_checker
  import grps_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic clk_stop_rst_i,
  input wire logic ce_rst_i,
  input wire logic [6:0] addr_i,
  input wire logic [3:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [3:0] rdata_o,
  input wire logic alu_go_i,
  input wire logic [1:0] alu_op_i,
  input wire logic alu_cmp_only_i,
  input wire logic [6:0] alu_dst_i,
  input wire logic [10:0] mem_addr_i,
  input wire logic [10:0] index_i,
  input wire logic [6:0] gr_pointer_o,
  input wire logic [1:0] gr_bank_o,
  input wire logic [2:0] gr_row_o,
  input wire logic decimal_mode_o,
  input wire logic compare_flag_o,
  input wire logic carry_flag_o,
  input wire logic zero_flag_o,
  input wire logic index_enable_flag_o,
  input wire logic [10:0] mem_addr_o,
  input wire logic alu_valid_o
);
  // All three resets act alike, so any of them holds checks off
  wire logic rst = srst_i | clk_stop_rst_i | ce_rst_i;
  // Software write with no ALU operation issued on the same edge
  wire logic wr_ok = wr_i & !alu_go_i;
  wire logic [3:0] st = {compare_flag_o, carry_flag_o, zero_flag_o,
    index_enable_flag_o};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst);
  property p_ptr; gr_pointer_o == {3'h0, gr_bank_o[0], gr_row_o};
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer");
  property p_bank; gr_bank_o[1] == 1'b0; endproperty
  a_bank: assert property (p_bank) else $error("bank");
  property p_hi; wr_ok && !$past(alu_go_i) && addr_i == GRPS_ADDR_PTR_HI
    |=> gr_bank_o == {1'b0, $past(wdata_i[0])}; endproperty
  a_hi: assert property (p_hi) else $error("hi nibble");
  property p_lo; wr_ok && !$past(alu_go_i) && addr_i == GRPS_ADDR_PTR_LO
    |=> gr_row_o == $past(wdata_i[3:1]) &&
    decimal_mode_o == $past(wdata_i[0]); endproperty
  a_lo: assert property (p_lo) else $error("lo nibble");
  property p_st; wr_ok && !$past(alu_go_i) && addr_i == GRPS_ADDR_STATUS
    |=> st == $past(wdata_i); endproperty
  a_st: assert property (p_st) else $error("status");
  property p_rz; rd_i && addr_i == GRPS_ADDR_PTR_HI |=>
    rdata_o[3:1] == 3'h0; endproperty
  a_rz: assert property (p_rz) else $error("fixed bits");
  property p_idle; !rd_i |=> rdata_o == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle read");
  property p_rst; disable iff (1'b0) rst |=>
    gr_pointer_o == 7'h00 && st == 4'h0 && !decimal_mode_o; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_ix; !$past(rst) && $stable(index_enable_flag_o) |->
    mem_addr_o == (index_enable_flag_o ? $past(mem_addr_i) |
    $past(index_i) : $past(mem_addr_i)); endproperty
  a_ix: assert property (p_ix) else $error("index");
  property p_val; alu_go_i && alu_op_i != 2'h0 && !alu_cmp_only_i &&
    alu_dst_i < GRPS_ADDR_PTR_HI |-> ##2 alu_valid_o; endproperty
  a_val: assert property (p_val) else $error("alu valid");
  c_hi: cover property (p_hi);
  c_val: cover property (alu_valid_o);
  c_ce: cover property (disable iff (1'b0) ce_rst_i);
endmodule
bind grps_top grps_top_checker grps_top_checker_inst (.*);
`default_nettype wire

/* File: sim/grps_top_tb.sv */
// Self-checking bench for the pointer and status word block.
// Drives every port itself; read data stands one cycle late.
`default_nettype none
module grps_top_tb
  import grps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0, srst_i = 1'b1, clk_stop_rst_i = 1'b0;
  logic ce_rst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, alu_go_i = 1'b0;
  // Carry-in and compare forms are left out for want of room
  logic alu_use_carry_i = 1'b0, alu_cmp_only_i = 1'b0;
  logic [6:0] addr_i = 7'h00, alu_dst_i = 7'h00, gr_pointer_o, a;
  logic [3:0] wdata_i = 4'h0, alu_a_i = 4'h0, alu_b_i = 4'h0;
  logic [3:0] rdata_o, alu_result_o, d, x, y;
  logic [3:0] m_q [4];
  logic [1:0] alu_op_i = 2'h0, gr_bank_o;
  logic [2:0] gr_row_o;
  logic [10:0] mem_addr_i = 11'h000, index_i = 11'h000, mem_addr_o;
  logic decimal_mode_o, compare_flag_o, carry_flag_o, zero_flag_o;
  logic index_enable_flag_o, alu_valid_o;
  int fail_count = 0, n_tests = 0, i;
  grps_top grps_top_inst (.*);
  initial forever #12.5 clk_i = ~clk_i;
  // Address inputs wander so index modification sees both flag states
  always @(posedge clk_i) begin
    mem_addr_i <= 11'($urandom);
    index_i <= 11'($urandom);
  end
  task automatic chk(string n, logic [6:0] s, logic [6:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [6:0] t, logic [3:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= t;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Data are looked at in the one cycle that they stand
  task automatic rd(logic [6:0] t, logic [3:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= t;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", {3'h0, rdata_o}, {3'h0, e});
  endtask
  // Decimal adjust covers additions only; operands kept below ten
  // Bit 4 of the answer is the expected carry or borrow flag
  function automatic logic [4:0] f_res(logic s, logic dc, logic [3:0] p,
      logic [3:0] q);
    logic [4:0] r;
    r = s ? {1'b0, p} - {1'b0, q} : {1'b0, p} + {1'b0, q};
    if (dc && r > GRPS_BCD_LIMIT) r = r + GRPS_BCD_ADJ;
    return r;
  endfunction
  task automatic alu(logic s, logic [3:0] p, logic [3:0] q, logic [6:0] t,
      logic dc);
    logic [4:0] r;
    @(posedge clk_i);
    alu_go_i <= 1'b1;
    alu_op_i <= s ? GRPS_OP_SUB : GRPS_OP_ADD;
    alu_a_i <= p;
    alu_b_i <= q;
    alu_dst_i <= t;
    @(posedge clk_i);
    alu_go_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    r = f_res(s, dc, p, q);
    if (t == GRPS_ADDR_STATUS) rd(t, r[3:0]);
    else begin
      chk("res", {3'h0, alu_result_o}, {3'h0, r[3:0]});
      chk("cy", {6'h00, carry_flag_o}, {6'h00, r[4]});
      chk("z", {6'h00, zero_flag_o}, {6'h00, r[3:0] == 4'h0});
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'ha25a));
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    m_q = '{default: 4'h0};
    for (i = 1; i < 4; i++) rd(7'h7c + 7'(i), 4'h0);
    rd(7'h20, 4'h0);
    // Random nibble writes; fixed-zero bits must drop what is written
    for (i = 0; i < 30; i++) begin
      a = GRPS_ADDR_PTR_HI + 7'($urandom_range(2));
      d = i < 2 ? 4'hf : 4'($urandom);
      wr(a, d);
      m_q[a[1:0]] = a == GRPS_ADDR_PTR_HI ? d & GRPS_ONE_NIB : d;
      rd(a, m_q[a[1:0]]);
      chk("ptr", gr_pointer_o, {3'h0, m_q[1][0], m_q[2][3:1]});
    end
    wr(GRPS_ADDR_PTR_LO, 4'h0);
    alu(1'b0, 4'h8, 4'h8, GRPS_ADDR_STATUS, 1'b0);
    for (i = 0; i < 16; i++) begin
      wr(GRPS_ADDR_PTR_LO, {3'h0, i[0]});
      x = 4'($urandom_range(9));
      y = 4'($urandom_range(9));
      alu(!i[0] & i[2], x, y, i[1] ? GRPS_ADDR_STATUS : 7'h10, i[0]);
    end
    // Clock-stop and CE resets, each in mid-run
    for (i = 0; i < 2; i++) begin
      wr(GRPS_ADDR_STATUS, 4'hf);
      wr(GRPS_ADDR_PTR_LO, 4'hf);
      @(posedge clk_i);
      clk_stop_rst_i <= !i[0];
      ce_rst_i <= i[0];
      @(posedge clk_i);
      clk_stop_rst_i <= 1'b0;
      ce_rst_i <= 1'b0;
      rd(GRPS_ADDR_STATUS, 4'h0);
      rd(GRPS_ADDR_PTR_LO, 4'h0);
    end
    stop_test();
  end
  // Whole run is well under a few thousand cycles
  initial begin
    #100us;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
